/* include/charger_map.vh */
`ifndef CHARGER_MAP_VH
`define CHARGER_MAP_VH

// Register byte offsets
`define REG_CTRL           8'h00
`define REG_TIMEOUT        8'h04
`define REG_STATUS         8'h08
`define REG_IRQ_STATUS     8'h0c
`define REG_IRQ_MASK       8'h10

// Reset values
`define CTRL_RESET         1'b0
`define TIMEOUT_RESET      32'h0000_3000
`define IRQ_MASK_RESET     3'h0

// Field positions
`define CTRL_SW_SUSPEND    0
`define STATUS_CV_MODE     4
`define STATUS_REVERSE     5
`define STATUS_ENABLED     6
`define STATUS_TIMER_HI    8
`define EVT_FAULT          0
`define EVT_COMPLETE       1
`define EVT_CYCLE_START    2
`define EVT_COUNT          3

// Charger states
`define ST_PRECOND         3'h0
`define ST_NORMAL          3'h1
`define ST_TOPOFF          3'h2
`define ST_SLEEP           3'h3
`define ST_SUSPEND         3'h4
`define ST_FAULT           3'h5
`define ST_NO_INPUT        3'h6

// Current requests and end-of-charge thresholds, percent of programmed charge current
`define PCT_OFF            7'h00
`define PCT_PRECOND        7'h0c
`define PCT_FULL           7'h64
`define PCT_EOC_HIGH       7'h0a
`define PCT_EOC_LOW        7'h05

// Precondition timeout is this fraction of the safety timeout
`define PRECOND_DIVISOR    2'h3

`endif

/* src/safety_timer.v */
`timescale 1ns/10ps
`default_nettype none
`include "charger_map.vh"

module safety_timer #(
  parameter WIDTH = 32
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clear,
  input  wire             run,
  input  wire [WIDTH-1:0] limit,
  output reg              precond_expired,
  output reg              total_expired,
  output wire [WIDTH-1:0] count
);

  reg  [WIDTH-1:0] count_reg;
  wire [WIDTH+1:0] count_scaled;

  // Saturates so a stalled fault never wraps back to a fresh cycle
  wire saturated = &count_reg;

  assign count = count_reg;
  assign count_scaled = {2'b00, count_reg} * {{WIDTH{1'b0}}, `PRECOND_DIVISOR};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg       <= {WIDTH{1'b0}};
      precond_expired <= 1'b0;
      total_expired   <= 1'b0;
    end else if (clear) begin
      count_reg       <= {WIDTH{1'b0}};
      precond_expired <= 1'b0;
      total_expired   <= 1'b0;
    end else begin
      if (run && !saturated)
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      precond_expired <= count_scaled >= {2'b00, limit};
      total_expired   <= count_reg >= limit;
    end
  end

endmodule // safety_timer

`default_nettype wire

/* src/event_irq.v */
`timescale 1ns/10ps
`default_nettype none

module event_irq #(
  parameter N = 3
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [N-1:0] event_pulse,
  input  wire [N-1:0] clear_bits,
  input  wire [N-1:0] mask,
  output reg  [N-1:0] status,
  output reg          irq
);

  wire [N-1:0] status_next = event_pulse | (status & ~clear_bits);

  // A new event in the clearing cycle survives the clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= {N{1'b0}};
      irq    <= 1'b0;
    end else begin
      status <= status_next;
      irq    <= |(status_next & mask);
    end
  end

endmodule // event_irq

`default_nettype wire

/* src/charger_ctrl.v */
// Contract
// - New cycle starts in precondition; above threshold moves to normal.
// - Precondition requests 12 percent of programmed charge current.
// - Precondition timeout before threshold flags damaged cell, enters fault.
// - Normal charges constant current, then constant voltage at termination.
// - In constant voltage, current below 10 or 5 percent enters top-off.
// - Normal timeout before leaving normal flags damaged cell, enters fault.
// - Top-off keeps constant voltage; end-of-charge current enters sleep.
// - End of charge presents high impedance yet keeps monitoring battery.
// - Enable input low suspends charging; other functions keep running.
// - Leaving suspend resets safety timer and enters precondition.
// - Sleep is high impedance; battery below termination restarts fast charge.
// - Valid charger input enables charging with no further command.
// - Input below battery reconfigures power switch to cut battery drain.
// - Precondition timeout is one third of safety timeout; charger off.
// - Status output sinks only while charging; released otherwise.
`timescale 1ns/10ps
`default_nettype none
`include "charger_map.vh"

module charger_ctrl #(
  parameter ADDR_W  = 8,
  parameter TIMER_W = 32
) (
  input  wire              clk,
  input  wire              rst_n,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  output reg               irq,
  // Comparator and pin inputs
  input  wire              charger_input_valid,
  input  wire              charger_input_below_battery,
  input  wire              battery_above_precondition,
  input  wire              battery_at_termination,
  input  wire              current_below_eoc,
  input  wire              input_type_select,
  input  wire              charge_enable,
  // Power path controls
  output reg  [6:0]        charge_current_pct,
  output reg  [6:0]        eoc_threshold_pct,
  output reg               cv_mode,
  output reg               battery_hiz,
  output reg               reverse_block,
  output reg               damaged_cell,
  output reg               charge_status_out,
  output reg               charge_status_oe
);

  localparam [2:0] S_PRECOND  = `ST_PRECOND;
  localparam [2:0] S_NORMAL   = `ST_NORMAL;
  localparam [2:0] S_TOPOFF   = `ST_TOPOFF;
  localparam [2:0] S_SLEEP    = `ST_SLEEP;
  localparam [2:0] S_SUSPEND  = `ST_SUSPEND;
  localparam [2:0] S_FAULT    = `ST_FAULT;
  localparam [2:0] S_NO_INPUT = `ST_NO_INPUT;

  reg  [2:0]         state_reg;
  reg  [2:0]         state_next;
  reg                cv_next;
  reg                timer_clear_reg;
  reg                timer_clear_next;
  reg                sw_suspend_reg;
  reg  [TIMER_W-1:0] timeout_reg;
  reg  [2:0]         irq_mask_reg;
  reg  [2:0]         irq_clear;
  reg  [2:0]         evt_pulse;
  wire [2:0]         irq_status;
  wire               irq_wire;
  wire               precond_expired;
  wire               total_expired;
  wire [TIMER_W-1:0] timer_count;
  wire               charging;

  // Charging states share the timer and the status indication
  function is_charging;
    input [2:0] st;
    begin
      is_charging = (st == S_PRECOND) || (st == S_NORMAL) || (st == S_TOPOFF);
    end
  endfunction

  assign charging = is_charging(state_reg);

  wire suspend_req = !charge_enable || sw_suspend_reg;

  // Charger state machine
  always @* begin
    state_next       = state_reg;
    cv_next          = cv_mode;
    timer_clear_next = 1'b0;
    if (!charger_input_valid) begin
      // Input loss also releases a latched fault
      state_next       = S_NO_INPUT;
      cv_next          = 1'b0;
      timer_clear_next = 1'b1;
    end else if (suspend_req) begin
      state_next       = S_SUSPEND;
      cv_next          = 1'b0;
      timer_clear_next = 1'b1;
    end else begin
      case (state_reg)
        S_NO_INPUT: begin
          state_next       = S_PRECOND;
          timer_clear_next = 1'b1;
        end
        S_SUSPEND: begin
          state_next       = S_PRECOND;
          timer_clear_next = 1'b1;
        end
        S_PRECOND: begin
          // Expiry flags are registered and lag the clear by one cycle;
          // a stale flag from the last cycle must not fault a fresh one
          if (battery_above_precondition)
            state_next = S_NORMAL;
          else if (precond_expired && !timer_clear_reg)
            state_next = S_FAULT;
        end
        S_NORMAL: begin
          // Sleep restarts here while the clear is still landing
          if (total_expired && !timer_clear_reg) begin
            state_next = S_FAULT;
            cv_next    = 1'b0;
          end else if (!cv_mode) begin
            if (battery_at_termination)
              cv_next = 1'b1;
          end else if (current_below_eoc) begin
            state_next = S_TOPOFF;
          end
        end
        S_TOPOFF: begin
          cv_next = 1'b1;
          if (current_below_eoc) begin
            state_next = S_SLEEP;
            cv_next    = 1'b0;
          end
        end
        S_SLEEP: begin
          // Monitoring continues while the battery floats
          if (!battery_at_termination) begin
            state_next       = S_NORMAL;
            timer_clear_next = 1'b1;
          end
        end
        S_FAULT: begin
          state_next = S_FAULT;
          cv_next    = 1'b0;
        end
        default: begin
          state_next       = S_NO_INPUT;
          cv_next          = 1'b0;
          timer_clear_next = 1'b1;
        end
      endcase
    end
  end

  always @* begin
    evt_pulse = 3'h0;
    evt_pulse[`EVT_FAULT] = (state_next == S_FAULT) && (state_reg != S_FAULT);
    evt_pulse[`EVT_COMPLETE] = (state_next == S_SLEEP) && (state_reg != S_SLEEP);
    evt_pulse[`EVT_CYCLE_START] = (state_next == S_PRECOND) && (state_reg != S_PRECOND);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg          <= S_NO_INPUT;
      cv_mode            <= 1'b0;
      timer_clear_reg    <= 1'b1;
      charge_current_pct <= `PCT_OFF;
      eoc_threshold_pct  <= `PCT_EOC_LOW;
      battery_hiz        <= 1'b1;
      reverse_block      <= 1'b0;
      damaged_cell       <= 1'b0;
      charge_status_out  <= 1'b0;
      charge_status_oe   <= 1'b0;
    end else begin
      state_reg       <= state_next;
      cv_mode         <= cv_next;
      timer_clear_reg <= timer_clear_next;
      case (state_next)
        S_PRECOND: charge_current_pct <= `PCT_PRECOND;
        S_NORMAL:  charge_current_pct <= `PCT_FULL;
        S_TOPOFF:  charge_current_pct <= `PCT_FULL;
        default:   charge_current_pct <= `PCT_OFF;
      endcase
      eoc_threshold_pct <= input_type_select ? `PCT_EOC_HIGH : `PCT_EOC_LOW;
      battery_hiz <= !is_charging(state_next);
      reverse_block <= charger_input_below_battery;
      damaged_cell <= (state_next == S_FAULT);
      // Open drain: sinks low only while charging
      charge_status_out <= 1'b0;
      charge_status_oe  <= is_charging(state_next);
    end
  end

  // Timer runs only during charging states and clears on each new cycle
  safety_timer #(
    .WIDTH (TIMER_W)
  ) u_timer (
    .clk             (clk),
    .rst_n           (rst_n),
    .clear           (timer_clear_reg),
    .run             (charging),
    .limit           (timeout_reg),
    .precond_expired (precond_expired),
    .total_expired   (total_expired),
    .count           (timer_count)
  );

  event_irq #(
    .N (`EVT_COUNT)
  ) u_irq (
    .clk         (clk),
    .rst_n       (rst_n),
    .event_pulse (evt_pulse),
    .clear_bits  (irq_clear),
    .mask        (irq_mask_reg),
    .status      (irq_status),
    .irq         (irq_wire)
  );

  // APB slave: one wait state so read data comes from a flip-flop
  wire access   = psel && penable;
  wire complete = access && pready;
  wire [7:0] addr8 = paddr[7:0];

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `REG_CTRL) || (a == `REG_TIMEOUT) || (a == `REG_STATUS) ||
               (a == `REG_IRQ_STATUS) || (a == `REG_IRQ_MASK);
    end
  endfunction

  reg [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h0000_0000;
    case (addr8)
      `REG_CTRL:       rdata_next[`CTRL_SW_SUSPEND] = sw_suspend_reg;
      `REG_TIMEOUT:    rdata_next = timeout_reg;
      `REG_STATUS: begin
        rdata_next[2:0]             = state_reg;
        rdata_next[`STATUS_CV_MODE] = cv_mode;
        rdata_next[`STATUS_REVERSE] = reverse_block;
        rdata_next[`STATUS_ENABLED] = charging;
        rdata_next[31:`STATUS_TIMER_HI] = timer_count[TIMER_W-1:`STATUS_TIMER_HI];
      end
      `REG_IRQ_STATUS: rdata_next[2:0] = irq_status;
      `REG_IRQ_MASK:   rdata_next[2:0] = irq_mask_reg;
      default:         rdata_next = 32'h0000_0000;
    endcase
  end

  always @* begin
    irq_clear = 3'h0;
    if (complete && pwrite && !pslverr && addr8 == `REG_IRQ_STATUS)
      irq_clear = pwdata[2:0];
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      prdata         <= 32'h0000_0000;
      irq            <= 1'b0;
      sw_suspend_reg <= `CTRL_RESET;
      timeout_reg    <= `TIMEOUT_RESET;
      irq_mask_reg   <= `IRQ_MASK_RESET;
    end else begin
      irq <= irq_wire;
      if (access && !pready) begin
        pready  <= 1'b1;
        pslverr <= !mapped(addr8) || (pwrite && addr8 == `REG_STATUS);
        prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
      if (complete && pwrite && !pslverr) begin
        case (addr8)
          `REG_CTRL:     sw_suspend_reg <= pwdata[`CTRL_SW_SUSPEND];
          `REG_TIMEOUT:  timeout_reg    <= pwdata[TIMER_W-1:0];
          `REG_IRQ_MASK: irq_mask_reg   <= pwdata[2:0];
          default:       sw_suspend_reg <= sw_suspend_reg;
        endcase
      end
    end
  end

endmodule // charger_ctrl

`default_nettype wire

/* dv/charger_ctrl_checker.sv */
`timescale 1ns/10ps
`default_nettype none

module charger_ctrl_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       charger_input_valid,
  input wire logic       charger_input_below_battery,
  input wire logic       input_type_select,
  input wire logic       charge_enable,
  input wire logic [6:0] charge_current_pct,
  input wire logic [6:0] eoc_threshold_pct,
  input wire logic       battery_hiz,
  input wire logic       reverse_block,
  input wire logic       damaged_cell,
  input wire logic       charge_status_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bus answer missing");
  property p_eoc_sel;
    1'b1 |=> eoc_threshold_pct == ($past(input_type_select) ? 7'h0a : 7'h05);
  endproperty
  a_eoc_sel: assert property (p_eoc_sel) else $error("eoc fraction wrong");
  property p_suspend;
    !charge_enable |=> battery_hiz && charge_current_pct == 7'h00;
  endproperty
  a_suspend: assert property (p_suspend) else $error("charging while suspended");
  property p_no_input;
    !charger_input_valid |=> battery_hiz && !charge_status_oe;
  endproperty
  a_no_input: assert property (p_no_input) else $error("charging without input");
  property p_reverse;
    charger_input_below_battery |=> reverse_block;
  endproperty
  a_reverse: assert property (p_reverse) else $error("switch not reconfigured");
  property p_status;
    charge_status_oe |-> !battery_hiz && charge_current_pct != 7'h00;
  endproperty
  a_status: assert property (p_status) else $error("status on while idle");
  property p_fault_off;
    $rose(damaged_cell) |-> battery_hiz && charge_current_pct == 7'h00 && !charge_status_oe;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault left charger on");
  property p_fault_hold;
    damaged_cell && charger_input_valid && charge_enable |=> damaged_cell;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault left early");
endmodule // charger_ctrl_checker

bind charger_ctrl charger_ctrl_checker i_charger_ctrl_checker (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .charger_input_valid(charger_input_valid), .input_type_select(input_type_select),
  .charger_input_below_battery(charger_input_below_battery), .charge_enable(charge_enable),
  .charge_current_pct(charge_current_pct), .eoc_threshold_pct(eoc_threshold_pct),
  .battery_hiz(battery_hiz), .reverse_block(reverse_block), .damaged_cell(damaged_cell),
  .charge_status_oe(charge_status_oe)
);
`default_nettype wire

/* dv/battery_model.sv */
`timescale 1ns/10ps
`default_nettype none

module battery_model #(
  parameter logic [7:0] PRE_LVL  = 8'h08,
  parameter logic [7:0] TERM_LVL = 8'h14
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] charge_current_pct,
  input  wire logic       battery_hiz,
  input  wire logic [6:0] eoc_threshold_pct,
  input  wire logic       load,
  input  wire logic [7:0] lvl,
  input  wire logic       stuck,
  output wire logic       battery_above_precondition,
  output wire logic       battery_at_termination,
  output wire logic       current_below_eoc
);
  logic [7:0] vbat;
  logic [7:0] cur;
  // Coarse taper step keeps the run short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbat <= 8'h00;
      cur  <= 8'h64;
    end else if (load) begin
      vbat <= lvl;
      cur  <= 8'h64;
    end else begin
      if (!battery_hiz && charge_current_pct != 7'h00 && !stuck && vbat < TERM_LVL)
        vbat <= vbat + 8'h01;
      if (vbat < TERM_LVL)
        cur <= 8'h64;
      else if (cur >= 8'h08)
        cur <= cur - 8'h08;
    end
  end
  assign battery_above_precondition = vbat > PRE_LVL;
  assign battery_at_termination     = vbat >= TERM_LVL;
  assign current_below_eoc          = cur < {1'b0, eoc_threshold_pct};
endmodule // battery_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "charger_map.vh"

module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        valid = 1'b0;
  logic        below_bat = 1'b0;
  logic        type_sel = 1'b0;
  logic        enable = 1'b1;
  logic        load = 1'b0;
  logic        stuck = 1'b0;
  logic [7:0]  lvl = 8'h00;
  logic [31:0] rdat;
  logic        rerr;
  integer      miscompares = 0;
  integer      comparisons = 0;
  wire  [31:0] prdata;
  wire  [6:0]  pct, eoc_pct;
  wire         pready, pslverr, irq, above_pre, at_term, below_eoc, cv, hiz, rev, dmg;
  wire         st_out, st_oe;

  always #50 clk = ~clk;

  charger_ctrl i_charger_ctrl (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .charger_input_valid(valid), .charger_input_below_battery(below_bat),
    .battery_above_precondition(above_pre), .battery_at_termination(at_term),
    .current_below_eoc(below_eoc), .input_type_select(type_sel), .charge_enable(enable),
    .charge_current_pct(pct), .eoc_threshold_pct(eoc_pct), .cv_mode(cv),
    .battery_hiz(hiz), .reverse_block(rev), .damaged_cell(dmg),
    .charge_status_out(st_out), .charge_status_oe(st_oe)
  );

  battery_model i_battery_model (
    .clk(clk), .rst_n(rst_n), .charge_current_pct(pct), .battery_hiz(hiz),
    .eoc_threshold_pct(eoc_pct), .load(load), .lvl(lvl), .stuck(stuck),
    .battery_above_precondition(above_pre), .battery_at_termination(at_term),
    .current_below_eoc(below_eoc)
  );

  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered right after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      chk({31'h0, pready}, 32'h1);
      report_and_stop();
    end
    @(posedge clk);
  endtask

  task automatic wait_state(input logic [2:0] s);
    integer i;
    i = 0;
    apb(1'b0, `REG_STATUS, 32'h0);
    while (rdat[2:0] !== s && i < 60) begin
      apb(1'b0, `REG_STATUS, 32'h0);
      i++;
    end
    chk({29'h0, rdat[2:0]}, {29'h0, s});
    if (rdat[2:0] !== s)
      report_and_stop();
  endtask

  task automatic wait_fault(input integer lim);
    integer i;
    i = 0;
    while (dmg !== 1'b1 && i < lim) begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, dmg}, 32'h1);
    if (dmg !== 1'b1)
      report_and_stop();
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, `REG_TIMEOUT, 32'h0);
    chk(rdat, 32'h0000_3000);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, `REG_STATUS, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wait_state(`ST_NO_INPUT);
    apb(1'b1, `REG_TIMEOUT, 32'h60);
    apb(1'b1, `REG_IRQ_MASK, 32'h7);
    valid <= 1'b1;
    repeat (2) @(posedge clk);
    chk({25'h0, pct}, 32'hc);
    chk({31'h0, st_oe}, 32'h1);
    chk({31'h0, st_out}, 32'h0);
    wait_state(`ST_NORMAL);
    chk({25'h0, pct}, 32'h64);
    wait_state(`ST_SLEEP);
    chk({31'h0, hiz}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk(rdat, 32'h6);
    apb(1'b1, `REG_IRQ_STATUS, 32'h6);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `REG_CTRL, 32'h1);
    wait_state(`ST_SUSPEND);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rdat, 32'h1);
    apb(1'b1, `REG_CTRL, 32'h0);
    wait_state(`ST_SLEEP);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    chk(rdat, 32'h6);
    apb(1'b1, `REG_IRQ_STATUS, 32'h6);
    lvl <= 8'h0f;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wait_state(`ST_NORMAL);
    type_sel <= 1'b1;
    below_bat <= 1'b1;
    repeat (2) @(posedge clk);
    chk({25'h0, eoc_pct}, 32'ha);
    chk({31'h0, rev}, 32'h1);
    type_sel <= 1'b0;
    below_bat <= 1'b0;
    repeat (2) @(posedge clk);
    chk({25'h0, eoc_pct}, 32'h5);
    chk({31'h0, cv}, 32'h1);
    enable <= 1'b0;
    wait_state(`ST_SUSPEND);
    chk({25'h0, pct}, 32'h0);
    chk({31'h0, cv}, 32'h0);
    lvl <= 8'h00;
    load <= 1'b1;
    stuck <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    enable <= 1'b1;
    wait_state(`ST_PRECOND);
    repeat (20) @(posedge clk);
    chk({31'h0, dmg}, 32'h0);
    wait_fault(20);
    chk({31'h0, st_oe}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wait_state(`ST_FAULT);
    enable <= 1'b0;
    stuck <= 1'b0;
    repeat (2) @(posedge clk);
    enable <= 1'b1;
    wait_state(`ST_NORMAL);
    stuck <= 1'b1;
    wait_fault(150);
    valid <= 1'b0;
    wait_state(`ST_NO_INPUT);
    chk({31'h0, dmg}, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
